// File: hdl/rxdma_cfg.svh
// Offsets, field positions, reset values and constants of the receive DMA run control
`ifndef RXDMA_CFG_SVH
`define RXDMA_CFG_SVH

// Register byte offsets on the AHB-Lite port
`define OFS_OPMODE 8'h00
`define OFS_STATUS 8'h04
`define OFS_RX_BASE 8'h08
`define OFS_RX_POLL 8'h0c
`define OFS_RX_CUR 8'h10

// Operation mode fields
`define BIT_RX_RUN 1
`define BIT_SECOND_FRAME 2
`define THR_LO 3
`define THR_HI 4
`define BIT_STORE_FWD 25

// Status fields
`define BIT_RBU 7
`define STATE_LO 17
`define STATE_HI 19

// Receive threshold per code, in bytes
`define THR_CODE00 16'h0040
`define THR_CODE01 16'h0020
`define THR_CODE10 16'h0060
`define THR_CODE11 16'h0080

// Descriptor stride and reset values
`define RXD_STRIDE 32'h0000_0010
`define RST_WORD 32'h0000_0000
`define RST_THR 2'h0

// Bus encodings
`define HTRANS_NONSEQ_BIT 1
`define HSIZE_WORD 3'h2
`define HRESP_OKAY 1'h0

`endif

// File: hdl/rxdma_pkg.sv
// Types shared by the receive DMA run control modules
package rxdma_pkg;

  // Receive process states, Gray coded along stop-fetch-wait-transfer-close
  typedef enum logic [2:0] {
    RX_STOPPED = 3'h0,
    RX_FETCH = 3'h1,
    RX_WAIT = 3'h3,
    RX_XFER = 3'h2,
    RX_CLOSE = 3'h6,
    RX_SUSPEND = 3'h7
  } rx_state_t;

  // One register write from the bus slave
  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [31:0] data;
  } reg_wr_t;

  // Threshold configuration handed to the FIFO gate
  typedef struct packed {
    logic [1:0] code;
    logic store_fwd;
  } rx_thr_cfg_t;

endpackage

// File: hdl/ahb_lite_slave.sv
// AHB-Lite slave front end: zero wait state, word accesses, registered read data
`timescale 1ns/10ps
`default_nettype none
`include "rxdma_cfg.svh"

module ahb_lite_slave
  import rxdma_pkg::*;
#(
  parameter int AW = 8
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic [AW-1:0] rd_addr,
  input wire logic [31:0] rd_data,
  output reg_wr_t reg_wr
);

  logic accept;
  logic ph_wr;
  logic [AW-1:0] ph_addr;

  // Only whole-word transfers are taken; others complete with no effect
  assign accept = hsel & hready & htrans[`HTRANS_NONSEQ_BIT] & (hsize == `HSIZE_WORD);
  assign rd_addr = haddr[AW-1:0];

  // Write address phase is held until the data phase brings hwdata
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ph_wr <= 1'b0;
      ph_addr <= '0;
    end
    else
    begin
      ph_wr <= accept & hwrite;
      ph_addr <= haddr[AW-1:0];
    end
  end

  // Read data sampled at the end of the address phase, so no wait state
  always_ff @(posedge clk)
  begin
    if (rst)
      hrdata <= `RST_WORD;
    else if (accept & ~hwrite)
      hrdata <= rd_data;
    else
      hrdata <= `RST_WORD;
  end

  // Never stretches, never errors
  always_ff @(posedge clk)
  begin
    hreadyout <= 1'b1;
    hresp <= `HRESP_OKAY;
  end

  assign reg_wr.en = ph_wr;
  assign reg_wr.addr = 8'(ph_addr); // Sized on purpose to the register offset width
  assign reg_wr.data = hwdata;

endmodule // ahb_lite_slave

`default_nettype wire

// File: hdl/rx_threshold_gate.sv
// Receive FIFO threshold gate: decides when the FIFO may ask for a DMA transfer
`timescale 1ns/10ps
`default_nettype none
`include "rxdma_cfg.svh"

module rx_threshold_gate
  import rxdma_pkg::*;
#(
  parameter int BW = 16
)
(
  input wire logic clk,
  input wire logic rst,
  input wire rx_thr_cfg_t cfg,
  input wire logic [BW-1:0] bytes_held,
  input wire logic frame_full,
  output logic xfer_req
);

  // Code to byte count
  function automatic logic [15:0] thr_bytes(input logic [1:0] code);
    case (code)
      2'h0: thr_bytes = `THR_CODE00;
      2'h1: thr_bytes = `THR_CODE01;
      2'h2: thr_bytes = `THR_CODE10;
      default: thr_bytes = `THR_CODE11;
    endcase
  endfunction

  logic over_thr;

  // Strictly above the threshold; store-and-forward waits for whole frames
  assign over_thr = ({{(32 - BW){1'b0}}, bytes_held} > {16'h0000, thr_bytes(cfg.code)});

  // Registered so the request reaches the DMA one cycle after the fill level
  always_ff @(posedge clk)
  begin
    if (rst)
      xfer_req <= 1'b0;
    else
      xfer_req <= frame_full | (~cfg.store_fwd & over_thr);
  end

endmodule // rx_threshold_gate

`default_nettype wire

// File: hdl/rx_dma_run_control.sv
// Receive DMA run control: start/stop/suspend of reception, list position, registers
`timescale 1ns/10ps
`default_nettype none
`include "rxdma_cfg.svh"

module rx_dma_run_control
  import rxdma_pkg::*;
#(
  parameter int BW = 16
)
(
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic [31:0] HRDATA,
  output logic HRESP,
  output logic DESC_RD_REQ,
  output logic DESC_WB_REQ,
  output logic [31:0] DESC_ADDR,
  input wire logic DESC_RD_ACK,
  input wire logic DESC_OWN,
  input wire logic DESC_RING_END,
  input wire logic DESC_WB_ACK,
  input wire logic [BW-1:0] FIFO_BYTES,
  input wire logic FIFO_FRAME_FULL,
  output logic FRAME_XFER_REQ,
  output logic FRAME_XFER_EN,
  input wire logic FRAME_DONE,
  input wire logic TX_STATUS_PENDING,
  output logic TX_NEXT_FRAME_OK,
  output logic [2:0] RX_STATE
);

  reg_wr_t reg_wr;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  rx_thr_cfg_t thr_cfg;

  logic rx_run;
  logic second_frame_overlap;
  logic [1:0] thr_code;
  logic rx_store_forward;
  logic [31:0] list_base;
  logic [31:0] cur_ptr;
  logic [31:0] next_cur_ptr;
  logic ring_end;
  logic rbu;
  rx_state_t state;
  rx_state_t next_state;
  logic xfer_req;

  // True when this cycle's bus write hits the given offset
  function automatic logic hit(input reg_wr_t w, input logic [7:0] ofs);
    hit = w.en & (w.addr == ofs);
  endfunction

  // Bus front end
  ahb_lite_slave #(
    .AW(8)
  ) u_slave (
    .clk(MCLK),
    .rst(SRST),
    .hsel(HSEL),
    .haddr(HADDR),
    .htrans(HTRANS),
    .hwrite(HWRITE),
    .hsize(HSIZE),
    .hwdata(HWDATA),
    .hready(HREADY),
    .hreadyout(HREADYOUT),
    .hrdata(HRDATA),
    .hresp(HRESP),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .reg_wr(reg_wr)
  );

  assign thr_cfg.code = thr_code;
  assign thr_cfg.store_fwd = rx_store_forward;

  // FIFO side transfer request
  rx_threshold_gate #(
    .BW(BW)
  ) u_thr (
    .clk(MCLK),
    .rst(SRST),
    .cfg(thr_cfg),
    .bytes_held(FIFO_BYTES),
    .frame_full(FIFO_FRAME_FULL),
    .xfer_req(xfer_req)
  );

  assign FRAME_XFER_REQ = xfer_req;

  // Operation mode register
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      rx_run <= 1'b0;
      second_frame_overlap <= 1'b0;
      thr_code <= `RST_THR;
      rx_store_forward <= 1'b0;
    end
    else if (hit(reg_wr, `OFS_OPMODE))
    begin
      rx_run <= reg_wr.data[`BIT_RX_RUN];
      second_frame_overlap <= reg_wr.data[`BIT_SECOND_FRAME];
      thr_code <= reg_wr.data[`THR_HI:`THR_LO];
      rx_store_forward <= reg_wr.data[`BIT_STORE_FWD];
    end
  end

  // List base; software owns its validity before the first start
  always_ff @(posedge MCLK)
  begin
    if (SRST)
      list_base <= `RST_WORD;
    else if (hit(reg_wr, `OFS_RX_BASE))
      list_base <= reg_wr.data;
  end

  // Receive process sequencing
  always_comb
  begin
    next_state = state;
    case (state)
      RX_STOPPED:
        if (rx_run)
          next_state = RX_FETCH;
      RX_FETCH:
        if (DESC_RD_ACK)
          next_state = DESC_OWN ? RX_WAIT : RX_SUSPEND;
      RX_WAIT:
        if (!rx_run)
          next_state = RX_STOPPED;
        else if (xfer_req)
          next_state = RX_XFER;
      RX_XFER:
        if (FRAME_DONE)
          next_state = RX_CLOSE;
      RX_CLOSE:
        if (DESC_WB_ACK)
          next_state = rx_run ? RX_FETCH : RX_STOPPED;
      RX_SUSPEND:
        if (!rx_run)
          next_state = RX_STOPPED;
        else if (hit(reg_wr, `OFS_RX_POLL))
          next_state = RX_FETCH;
      default:
        next_state = RX_STOPPED;
    endcase
  end

  always_ff @(posedge MCLK)
  begin
    if (SRST)
      state <= RX_STOPPED;
    else
      state <= next_state;
  end

  // Ring end flag of the descriptor now held
  always_ff @(posedge MCLK)
  begin
    if (SRST)
      ring_end <= 1'b0;
    else if (state == RX_FETCH && DESC_RD_ACK)
      ring_end <= DESC_RING_END;
  end

  // Current list position; advanced only once a descriptor is closed
  always_comb
  begin
    next_cur_ptr = cur_ptr;
    if (state == RX_STOPPED && hit(reg_wr, `OFS_RX_BASE))
      next_cur_ptr = reg_wr.data;
    else if (state == RX_CLOSE && DESC_WB_ACK)
      next_cur_ptr = ring_end ? list_base : cur_ptr + `RXD_STRIDE;
  end

  // Kept across stop and suspend so a restart resumes in place
  always_ff @(posedge MCLK)
  begin
    if (SRST)
      cur_ptr <= `RST_WORD;
    else
      cur_ptr <= next_cur_ptr;
  end

  // Buffer unavailable flag, write one to clear; a new event beats the clear
  always_ff @(posedge MCLK)
  begin
    if (SRST)
      rbu <= 1'b0;
    else if (state == RX_FETCH && DESC_RD_ACK && !DESC_OWN)
      rbu <= 1'b1;
    else if (hit(reg_wr, `OFS_STATUS) && reg_wr.data[`BIT_RBU])
      rbu <= 1'b0;
  end

  // Read mux; reads never have side effects
  always_comb
  begin
    rd_data = `RST_WORD;
    case (rd_addr)
      `OFS_OPMODE:
      begin
        rd_data[`BIT_RX_RUN] = rx_run;
        rd_data[`BIT_SECOND_FRAME] = second_frame_overlap;
        rd_data[`THR_HI:`THR_LO] = thr_code;
        rd_data[`BIT_STORE_FWD] = rx_store_forward;
      end
      `OFS_STATUS:
      begin
        rd_data[`BIT_RBU] = rbu;
        rd_data[`STATE_HI:`STATE_LO] = state;
      end
      `OFS_RX_BASE:
        rd_data = list_base;
      `OFS_RX_CUR:
        rd_data = cur_ptr;
      default:
        rd_data = `RST_WORD;
    endcase
  end

  // Memory side handshakes, registered from the next state
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      DESC_RD_REQ <= 1'b0;
      DESC_WB_REQ <= 1'b0;
      DESC_ADDR <= `RST_WORD;
    end
    else
    begin
      DESC_RD_REQ <= (next_state == RX_FETCH);
      DESC_WB_REQ <= (next_state == RX_CLOSE);
      DESC_ADDR <= next_cur_ptr;
    end
  end

  // Frame mover enable and visible state
  always_ff @(posedge MCLK)
  begin
    if (SRST)
    begin
      FRAME_XFER_EN <= 1'b0;
      RX_STATE <= RX_STOPPED;
    end
    else
    begin
      FRAME_XFER_EN <= (next_state == RX_XFER);
      RX_STATE <= next_state;
    end
  end

  // Transmit side may run ahead of the previous frame's status when allowed
  always_ff @(posedge MCLK)
  begin
    if (SRST)
      TX_NEXT_FRAME_OK <= 1'b0;
    else
      TX_NEXT_FRAME_OK <= second_frame_overlap | ~TX_STATUS_PENDING;
  end

endmodule // rx_dma_run_control

`default_nettype wire

// File: tb/rx_dma_run_control_monitor.sv
// Port-level checks of the receive DMA run control
`timescale 1ns/10ps
`default_nettype none

module rx_dma_run_control_monitor
  import rxdma_pkg::*;
(
  input wire logic MCLK,
  input wire logic SRST,
  input wire logic DESC_RD_REQ,
  input wire logic DESC_WB_REQ,
  input wire logic [31:0] DESC_ADDR,
  input wire logic DESC_RD_ACK,
  input wire logic DESC_OWN,
  input wire logic DESC_RING_END,
  input wire logic DESC_WB_ACK,
  input wire logic FIFO_FRAME_FULL,
  input wire logic FRAME_XFER_REQ,
  input wire logic FRAME_XFER_EN,
  input wire logic FRAME_DONE,
  input wire logic TX_STATUS_PENDING,
  input wire logic TX_NEXT_FRAME_OK,
  input wire logic [2:0] RX_STATE
);
  default clocking @(posedge MCLK);
  endclocking
  default disable iff (SRST);

  // Ring end of the last fetched descriptor; a wrapping close returns to the base instead
  logic wrap_held;
  always_ff @(posedge MCLK)
  begin
    if (SRST)
      wrap_held <= 1'b0;
    else if (DESC_RD_REQ && DESC_RD_ACK)
      wrap_held <= DESC_RING_END;
  end

  // Descriptor answers steer the state one cycle later
  property p_own; DESC_RD_REQ && DESC_RD_ACK && DESC_OWN |=> !DESC_RD_REQ && RX_STATE == RX_WAIT;
  endproperty
  a_own: assert property (p_own) else $error("owned fetch not waiting");
  property p_rbu; DESC_RD_REQ && DESC_RD_ACK && !DESC_OWN |=> RX_STATE == RX_SUSPEND; endproperty
  a_rbu: assert property (p_rbu) else $error("no suspend");
  property p_hold; DESC_RD_REQ && !DESC_RD_ACK |=> DESC_RD_REQ && $stable(DESC_ADDR); endproperty
  a_hold: assert property (p_hold) else $error("fetch position moved");
  property p_step; DESC_WB_REQ && DESC_WB_ACK && !wrap_held |=>
    DESC_ADDR == $past(DESC_ADDR) + 32'h10;
  endproperty
  a_step: assert property (p_step) else $error("position not advanced");
  // Frame end closes the buffer before any stop can land
  property p_done; FRAME_XFER_EN && FRAME_DONE |=> !FRAME_XFER_EN && DESC_WB_REQ; endproperty
  a_done: assert property (p_done) else $error("frame end not closed");
  property p_susp; RX_STATE == RX_SUSPEND |-> !DESC_RD_REQ && !FRAME_XFER_EN; endproperty
  a_susp: assert property (p_susp) else $error("suspended yet active");
  property p_full; FIFO_FRAME_FULL |=> FRAME_XFER_REQ; endproperty
  a_full: assert property (p_full) else $error("full frame not requested");
  // Sampled reset in the antecedent: the release edge itself still loads the reset value
  property p_tx; !SRST && !TX_STATUS_PENDING |=> TX_NEXT_FRAME_OK; endproperty
  a_tx: assert property (p_tx) else $error("next tx frame held");
endmodule // rx_dma_run_control_monitor

bind rx_dma_run_control rx_dma_run_control_monitor u_mon (.MCLK(MCLK), .SRST(SRST),
  .DESC_RD_REQ(DESC_RD_REQ), .DESC_WB_REQ(DESC_WB_REQ), .DESC_ADDR(DESC_ADDR),
  .DESC_RD_ACK(DESC_RD_ACK), .DESC_OWN(DESC_OWN), .DESC_RING_END(DESC_RING_END),
  .DESC_WB_ACK(DESC_WB_ACK),
  .FIFO_FRAME_FULL(FIFO_FRAME_FULL), .FRAME_XFER_REQ(FRAME_XFER_REQ),
  .FRAME_XFER_EN(FRAME_XFER_EN), .FRAME_DONE(FRAME_DONE),
  .TX_STATUS_PENDING(TX_STATUS_PENDING), .TX_NEXT_FRAME_OK(TX_NEXT_FRAME_OK),
  .RX_STATE(RX_STATE));

`default_nettype wire

// File: tb/rx_desc_mem_model.sv
// Descriptor memory model answering fetches and write backs
`timescale 1ns/10ps
`default_nettype none

module rx_desc_mem_model
(
  input wire logic clk,
  input wire logic rst,
  input wire logic rd_req,
  input wire logic wb_req,
  input wire logic owned,
  input wire logic slow,
  input wire logic ring,
  output logic rd_ack,
  output logic wb_ack,
  output logic own,
  output logic ring_end
);
  logic [2:0] cnt;

  // Wait counter, so the design also sees a slow memory
  always_ff @(posedge clk)
  begin
    if (rst || rd_ack || wb_ack || !(rd_req || wb_req))
      cnt <= 3'h0;
    else
      cnt <= cnt + 3'h1;
  end

  // One-cycle answers; outside them the flags show the opposite level
  assign rd_ack = rd_req && cnt == (slow ? 3'h4 : 3'h0);
  assign wb_ack = wb_req && cnt == (slow ? 3'h4 : 3'h0);
  assign own = rd_ack ? owned : !owned;
  assign ring_end = rd_ack ? ring : !ring;
endmodule // rx_desc_mem_model

`default_nettype wire

// File: tb/rx_dma_run_control_test.sv
// Self-checking bench of the receive DMA run control
`timescale 1ns/10ps
`default_nettype none

module rx_dma_run_control_test
  import rxdma_pkg::*;
;
  logic MCLK = 1'b0;
  logic SRST = 1'b1;
  logic [31:0] HADDR = 32'h0;
  logic [1:0] HTRANS = 2'h0;
  logic HWRITE = 1'b0;
  logic [31:0] HWDATA = 32'h0;
  logic [15:0] FIFO_BYTES = 16'h0;
  logic FIFO_FRAME_FULL = 1'b0;
  logic FRAME_DONE = 1'b0;
  logic TX_STATUS_PENDING = 1'b0;
  logic owned = 1'b1;
  logic slow = 1'b0;
  logic ring = 1'b0;
  logic HREADYOUT, HRESP, DESC_RD_REQ, DESC_WB_REQ, DESC_RD_ACK, DESC_OWN, DESC_RING_END;
  logic DESC_WB_ACK, FRAME_XFER_REQ, FRAME_XFER_EN, TX_NEXT_FRAME_OK;
  logic [31:0] HRDATA, DESC_ADDR, rdata;
  logic [2:0] RX_STATE;
  logic [15:0] thr [4] = '{16'h40, 16'h20, 16'h60, 16'h80};
  int fail_count = 0;
  int cmp_count = 0;

  always #50 MCLK = ~MCLK;

  rx_dma_run_control u_dut (.MCLK(MCLK), .SRST(SRST), .HSEL(1'b1), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
    .HREADYOUT(HREADYOUT), .HRDATA(HRDATA), .HRESP(HRESP), .DESC_RD_REQ(DESC_RD_REQ),
    .DESC_WB_REQ(DESC_WB_REQ), .DESC_ADDR(DESC_ADDR), .DESC_RD_ACK(DESC_RD_ACK),
    .DESC_OWN(DESC_OWN), .DESC_RING_END(DESC_RING_END), .DESC_WB_ACK(DESC_WB_ACK),
    .FIFO_BYTES(FIFO_BYTES), .FIFO_FRAME_FULL(FIFO_FRAME_FULL),
    .FRAME_XFER_REQ(FRAME_XFER_REQ), .FRAME_XFER_EN(FRAME_XFER_EN), .FRAME_DONE(FRAME_DONE),
    .TX_STATUS_PENDING(TX_STATUS_PENDING), .TX_NEXT_FRAME_OK(TX_NEXT_FRAME_OK),
    .RX_STATE(RX_STATE));

  rx_desc_mem_model u_mem (.clk(MCLK), .rst(SRST), .rd_req(DESC_RD_REQ), .wb_req(DESC_WB_REQ),
    .owned(owned), .slow(slow), .ring(ring), .rd_ack(DESC_RD_ACK), .wb_ack(DESC_WB_ACK),
    .own(DESC_OWN), .ring_end(DESC_RING_END));

  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s exp %h got %h", what, exp, got);
    end
  endtask

  // Bounded waits; running out counts as a mismatch and ends the run
  task automatic rdy;
    int n;
    n = 0;
    @(posedge MCLK);
    while (HREADYOUT !== 1'b1)
    begin
      if (++n > 20)
      begin
        chk("ready", 32'h1, 32'h0);
        end_sim;
      end
      @(posedge MCLK);
    end
  endtask

  task automatic wait_st(input rx_state_t s);
    int n;
    n = 0;
    while (RX_STATE !== s)
    begin
      if (++n > 60)
      begin
        chk("state", s, RX_STATE);
        end_sim;
      end
      @(posedge MCLK);
    end
  endtask

  // One word transfer; read data is taken at the edge closing the data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR <= {24'h0, a};
    rdy;
    HTRANS <= 2'h0;
    HWDATA <= d;
    rdy;
    rdata = HRDATA;
    chk("hresp", 32'h0, {31'h0, HRESP});
  endtask

  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, exp, rdata);
  endtask

  // Frame arrives and reaches the transfer state
  task automatic begin_frame;
    FIFO_FRAME_FULL <= 1'b1;
    wait_st(RX_XFER);
    FIFO_FRAME_FULL <= 1'b0;
  endtask

  task automatic done_pulse;
    FRAME_DONE <= 1'b1;
    @(posedge MCLK);
    FRAME_DONE <= 1'b0;
  endtask

  initial
  begin
    repeat (20) @(posedge MCLK);
    SRST <= 1'b0;
    rchk("opmode", 8'h00, 32'h0);
    rchk("unmapped", 8'h20, 32'h0);
    bus(1'b1, 8'h08, 32'h100);
    rchk("cur", 8'h10, 32'h100);
    // Each code: no request at the threshold, a request one byte above it
    for (int c = 0; c < 4; c++)
    begin
      bus(1'b1, 8'h00, {27'h0, c[1:0], 3'h0});
      FIFO_BYTES <= thr[c];
      repeat (2) @(posedge MCLK);
      chk("req at thr", 32'h0, {31'h0, FRAME_XFER_REQ});
      FIFO_BYTES <= thr[c] + 16'h1;
      repeat (2) @(posedge MCLK);
      chk("req over thr", 32'h1, {31'h0, FRAME_XFER_REQ});
    end
    bus(1'b1, 8'h00, 32'h0200_0000);
    repeat (2) @(posedge MCLK);
    chk("store fwd", 32'h0, {31'h0, FRAME_XFER_REQ});
    TX_STATUS_PENDING <= 1'b1;
    FIFO_BYTES <= 16'h0;
    repeat (2) @(posedge MCLK);
    chk("tx wait", 32'h0, {31'h0, TX_NEXT_FRAME_OK});
    bus(1'b1, 8'h00, 32'h4);
    repeat (2) @(posedge MCLK);
    chk("tx overlap", 32'h1, {31'h0, TX_NEXT_FRAME_OK});
    TX_STATUS_PENDING <= 1'b0;
    $display("test fifo and tx done");
    // Run one frame, then stop in mid-frame with a slow memory
    bus(1'b1, 8'h00, 32'h2);
    wait_st(RX_WAIT);
    chk("first addr", 32'h100, DESC_ADDR);
    begin_frame;
    done_pulse;
    wait_st(RX_WAIT);
    chk("next addr", 32'h110, DESC_ADDR);
    slow <= 1'b1;
    begin_frame;
    bus(1'b1, 8'h00, 32'h0);
    repeat (2) @(posedge MCLK);
    chk("stop waits", RX_XFER, RX_STATE);
    done_pulse;
    wait_st(RX_STOPPED);
    rchk("saved pos", 8'h10, 32'h120);
    bus(1'b1, 8'h00, 32'h2);
    wait_st(RX_WAIT);
    chk("restart addr", 32'h120, DESC_ADDR);
    $display("test run and stop done");
    // Suspend on a foreign descriptor, ignore a second start, resume by poll
    bus(1'b1, 8'h00, 32'h0);
    wait_st(RX_STOPPED);
    owned <= 1'b0;
    bus(1'b1, 8'h00, 32'h2);
    wait_st(RX_SUSPEND);
    rchk("status rbu", 8'h04, 32'h000e_0080);
    bus(1'b1, 8'h00, 32'h2);
    repeat (3) @(posedge MCLK);
    chk("start ignored", RX_SUSPEND, RX_STATE);
    chk("no refetch", 32'h0, {31'h0, DESC_RD_REQ});
    owned <= 1'b1;
    bus(1'b1, 8'h0c, 32'h1);
    wait_st(RX_WAIT);
    chk("resume addr", 32'h120, DESC_ADDR);
    bus(1'b1, 8'h04, 32'h80);
    rchk("status clr", 8'h04, 32'h0006_0000);
    $display("test suspend done");
    // Last descriptor of the ring: its close returns the position to the list base
    ring <= 1'b1;
    begin_frame;
    done_pulse;
    wait_st(RX_WAIT);
    chk("pre-wrap addr", 32'h130, DESC_ADDR);
    ring <= 1'b0;
    begin_frame;
    done_pulse;
    wait_st(RX_WAIT);
    chk("wrap addr", 32'h100, DESC_ADDR);
    $display("test ring wrap done");
    end_sim;
  end
endmodule // rx_dma_run_control_test

`default_nettype wire
